// *** design/mpoc_cfg.svh ***
`ifndef MPOC_CFG_SVH
`define MPOC_CFG_SVH
// register offsets (index on the register port)
`define MPOC_OPT_ADDR      8'h06
`define MPOC_STAT_ADDR     8'h08
`define MPOC_CNT_BASE      8'h10
// option register fields
`define MPOC_OPT_RESET     32'h0000_0800
`define MPOC_OPT_RSV_LSB   9
`define MPOC_OPT_RSV_VAL   23'h00_0004
`define MPOC_RDY_EMPTY_BIT 8
`define MPOC_SFD_SRC_BIT   7
`define MPOC_CLR_RD_BIT    6
`define MPOC_CRC_APP_BIT   5
`define MPOC_GAP_ADM_BIT   4
`define MPOC_FWD_UNK_BIT   2
// status register field
`define MPOC_FCS_ERR_BIT   11
// statistics counters
`define MPOC_CNT_NUM       4
`define MPOC_CNT_W         16
// crc32, reflected form
`define MPOC_CRC_POLY      32'hEDB8_8320
`define MPOC_CRC_INIT      32'hFFFF_FFFF
`define MPOC_CRC_RESIDUE   32'hDEBB_20E3
// management clock rates, khz, and derived half periods in cycles
`define MPOC_CLK_KHZ       50000
`define MPOC_MDC_SLOW_KHZ  2500
`define MPOC_MDC_FAST_KHZ  4166
`define MPOC_MDC_HALF_SLOW (`MPOC_CLK_KHZ / (2 * `MPOC_MDC_SLOW_KHZ))
`define MPOC_MDC_HALF_FAST (`MPOC_CLK_KHZ / (2 * `MPOC_MDC_FAST_KHZ))
// transmit buffer
`define MPOC_FIFO_DEPTH    4
`endif

// *** design/mpoc_pkg.sv ***
`default_nettype none
package mpoc_pkg;
   // one transmit byte with its end-of-frame marker
   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } mpoc_tx_word_t;
   // transmit sequencer, gray along idle -> data -> fcs
   typedef enum logic [1:0] {
      MPOC_IDLE = 2'b00,
      MPOC_DATA = 2'b01,
      MPOC_FCS  = 2'b11
   } mpoc_tx_state_t;
endpackage
`default_nettype wire

// *** design/mpoc_top.sv ***
`include "mpoc_cfg.svh"
`default_nettype none

// ------------------------------------------------------------
// transmit buffer
// ------------------------------------------------------------
module mpoc_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input  wire logic             i_mclk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_data,
   input  wire logic             i_valid,
   output logic                  o_ready,
   output logic [WIDTH-1:0]      o_data,
   output logic                  o_valid,
   input  wire logic             i_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    rd_reg;
   logic [AW:0]      cnt_reg;
   logic             push;
   logic             pop;
   assign push = i_valid & o_ready;
   assign pop  = o_valid & i_ready;
   assign o_data = mem_reg[rd_reg];

   // storage and pointers
   always_ff @(posedge i_mclk)
   begin
      if (push)
         mem_reg[wr_reg] <= i_data;
      if (i_rst)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
      end
      else
      begin
         if (push)
            wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
         if (pop)
            rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
   end

   // fill level with registered full and empty flags
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         cnt_reg <= '0;
         o_ready <= 1'b1;
         o_valid <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
         o_ready <= (cnt_reg + (AW+1)'(push) - (AW+1)'(pop))
                    != (AW+1)'(DEPTH);
         o_valid <= (cnt_reg + (AW+1)'(push) - (AW+1)'(pop)) != '0;
      end
   end
endmodule

// ------------------------------------------------------------
// option register and the datapath it steers
// ------------------------------------------------------------
// Summary of operation
// - tx ready pulses per sent frame, or on fifo empty when bit set
// - the on-empty choice applies only under the generic spi protocol
// - detect source 0 takes start-frame detection from the phy side
// - detect source 1 takes start-frame detection from the mac side
// - without clear-on-read, reads keep counters and counters wrap to zero
// - with clear-on-read, reads clear counters and counters saturate
// - clear-on-read governs only the statistics counters
// - generic protocol clear-on-read also clears the next counter
// - crc append bit adds fcs, otherwise host frame carries fcs
// - host crc32 checked during transmit, mismatch sets error flag
// - received crc32 goes to the host, which verifies it
// - admit-gap bit lets frames with short inter-frame gap in
// - forward bit decides if unmatched-address frames reach host
// - forwarded unmatched frames go to the low-priority fifo only
// - rate field 00 gives 2.5 mhz, 01 gives 4.166 mhz mdc
// - register 0x06 resets to 0x800, bits 31:9 read-only
// - bad-fcs frames still sent, error flag cleared by writing one
module mpoc_top (
   // clock and reset
   input  wire logic                  i_mclk,
   input  wire logic                  i_rst,
   // register port from the spi decoder
   input  wire logic                  i_reg_wr,
   input  wire logic                  i_reg_rd,
   input  wire logic [7:0]            i_reg_addr,
   input  wire logic [31:0]           i_reg_wdata,
   output logic      [31:0]           o_reg_rdata,
   output logic                       o_reg_rvalid,
   // pins and straps
   input  wire logic                  i_generic_spi,
   input  wire logic                  i_link_clk,
   input  wire logic                  i_sfd_phy,
   input  wire logic                  i_sfd_mac,
   // host transmit stream
   input  wire mpoc_pkg::mpoc_tx_word_t i_tx_word,
   input  wire logic                  i_tx_valid,
   output logic                       o_tx_ready,
   // link side
   output logic      [7:0]            o_link_data,
   output logic                       o_link_en,
   output logic                       o_tx_rdy,
   output logic                       o_ts_capture,
   output logic                       o_mdc,
   // receive side events
   input  wire logic [`MPOC_CNT_NUM-1:0] i_cnt_event,
   input  wire logic                  i_rx_unmatched,
   output logic                       o_rx_lowpri_push,
   output logic                       o_admit_gap_err
);
   import mpoc_pkg::*;

   logic [31:0]          opt_reg;
   logic                 fcs_flag_reg;
   logic [1:0]           gen_sync_reg;
   logic [2:0]           lclk_sync_reg;
   logic [2:0]           phy_sync_reg;
   logic [2:0]           mac_sync_reg;
   logic                 generic;
   logic                 link_rise;
   logic                 phy_evt;
   logic                 mac_evt;
   mpoc_tx_state_t       st_reg;
   logic [31:0]          crc_reg;
   logic [1:0]           fcs_idx_reg;
   logic                 done_reg;
   logic                 bad_reg;
   logic                 empty_d_reg;
   logic [4:0]           mdc_div_reg;
   logic [4:0]           mdc_half;
   mpoc_tx_word_t        fifo_word;
   logic                 fifo_valid;
   logic                 fifo_pop;
   logic [`MPOC_CNT_W-1:0] cnt_reg [`MPOC_CNT_NUM];

   // byte-wise crc32 update, reflected
   function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                            input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h00_0000, d};
      for (int b = 0; b < 8; b++)
         r = r[0] ? ((r >> 1) ^ `MPOC_CRC_POLY) : (r >> 1);
      return r;
   endfunction

   // counter address decode, shared by read data and clearing
   function automatic logic cnt_hit(input logic [7:0] a, input int i);
      return a == (`MPOC_CNT_BASE + 8'(i));
   endfunction

   // ------------------------------------------------------------
   // pin synchronisers, stage 0 feeds stage 1 only
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         gen_sync_reg  <= '0;
         lclk_sync_reg <= '0;
         phy_sync_reg  <= '0;
         mac_sync_reg  <= '0;
      end
      else
      begin
         gen_sync_reg  <= {gen_sync_reg[0], i_generic_spi};
         lclk_sync_reg <= {lclk_sync_reg[1:0], i_link_clk};
         phy_sync_reg  <= {phy_sync_reg[1:0], i_sfd_phy};
         mac_sync_reg  <= {mac_sync_reg[1:0], i_sfd_mac};
      end
   end
   assign generic   = gen_sync_reg[1];
   assign link_rise = lclk_sync_reg[1] & ~lclk_sync_reg[2];
   assign phy_evt   = phy_sync_reg[1] & ~phy_sync_reg[2];
   assign mac_evt   = mac_sync_reg[1] & ~mac_sync_reg[2];

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   // reset value
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         opt_reg <= `MPOC_OPT_RESET;
      else if (i_reg_wr && i_reg_addr == `MPOC_OPT_ADDR)
         opt_reg <= {`MPOC_OPT_RSV_VAL,
                     i_reg_wdata[`MPOC_OPT_RSV_LSB-1:0]};
   end

   // write-one-clear, a new error wins over the clear
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         fcs_flag_reg <= 1'b0;
      else if (bad_reg)
         fcs_flag_reg <= 1'b1;
      else if (i_reg_wr && i_reg_addr == `MPOC_STAT_ADDR
               && i_reg_wdata[`MPOC_FCS_ERR_BIT])
         fcs_flag_reg <= 1'b0;
   end

   // ------------------------------------------------------------
   // statistics counters
   // ------------------------------------------------------------
   for (genvar i = 0; i < `MPOC_CNT_NUM; i++)
   begin : g_cnt
      logic clr;
      logic sat;
      // generic protocol also clears the following counter
      assign clr = i_reg_rd && opt_reg[`MPOC_CLR_RD_BIT]
                   && (cnt_hit(i_reg_addr, i)
                       || (generic && i > 0 && cnt_hit(i_reg_addr, i - 1)));
      assign sat = opt_reg[`MPOC_CLR_RD_BIT] && (&cnt_reg[i]);
      always_ff @(posedge i_mclk)
      begin
         if (i_rst)
            cnt_reg[i] <= '0;
         // clear on read; an event in the same cycle still counts
         else if (clr)
            cnt_reg[i] <= `MPOC_CNT_W'(i_cnt_event[i]);
         else if (i_cnt_event[i] && !sat)
            cnt_reg[i] <= cnt_reg[i] + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // register reads, answered one cycle later
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_reg_rdata  <= '0;
         o_reg_rvalid <= 1'b0;
      end
      else
      begin
         o_reg_rvalid <= i_reg_rd;
         o_reg_rdata  <= '0;
         if (i_reg_rd)
         begin
            if (i_reg_addr == `MPOC_OPT_ADDR)
               o_reg_rdata <= opt_reg;
            else if (i_reg_addr == `MPOC_STAT_ADDR)
               o_reg_rdata[`MPOC_FCS_ERR_BIT] <= fcs_flag_reg;
            for (int i = 0; i < `MPOC_CNT_NUM; i++)
               if (cnt_hit(i_reg_addr, i))
                  o_reg_rdata <= {{(32 - `MPOC_CNT_W){1'b0}}, cnt_reg[i]};
         end
      end
   end

   // ------------------------------------------------------------
   // transmit path
   // ------------------------------------------------------------
   mpoc_fifo #(
      .WIDTH ($bits(mpoc_tx_word_t)),
      .DEPTH (`MPOC_FIFO_DEPTH)
   ) u_fifo (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_data  (i_tx_word),
      .i_valid (i_tx_valid),
      .o_ready (o_tx_ready),
      .o_data  (fifo_word),
      .o_valid (fifo_valid),
      .i_ready (fifo_pop)
   );
   // one byte per link edge; an empty fifo simply skips the edge
   assign fifo_pop = link_rise && fifo_valid && st_reg != MPOC_FCS;

   // sequencer: data bytes, then optional appended fcs
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         st_reg      <= MPOC_IDLE;
         crc_reg     <= `MPOC_CRC_INIT;
         fcs_idx_reg <= '0;
         o_link_data <= '0;
         o_link_en   <= 1'b0;
         done_reg    <= 1'b0;
         bad_reg     <= 1'b0;
      end
      else
      begin
         o_link_en <= 1'b0;
         done_reg  <= 1'b0;
         bad_reg   <= 1'b0;
         case (st_reg)
            MPOC_IDLE, MPOC_DATA:
               if (fifo_pop)
               begin
                  o_link_data <= fifo_word.data;
                  o_link_en   <= 1'b1;
                  crc_reg     <= crc_byte(crc_reg, fifo_word.data);
                  st_reg      <= MPOC_DATA;
                  if (fifo_word.last)
                  begin
                     if (opt_reg[`MPOC_CRC_APP_BIT])
                        st_reg <= MPOC_FCS;
                     else
                     begin
                        // host fcs must leave the known residue
                        // frame already sent, only flag it
                        bad_reg <= crc_byte(crc_reg, fifo_word.data)
                                   != `MPOC_CRC_RESIDUE;
                        done_reg <= 1'b1;
                        st_reg   <= MPOC_IDLE;
                        crc_reg  <= `MPOC_CRC_INIT;
                     end
                  end
               end
            MPOC_FCS:
               if (link_rise)
               begin
                  o_link_data <= ~crc_reg[8*fcs_idx_reg +: 8];
                  o_link_en   <= 1'b1;
                  fcs_idx_reg <= fcs_idx_reg + 1'b1;
                  if (fcs_idx_reg == 2'd3)
                  begin
                     done_reg <= 1'b1;
                     st_reg   <= MPOC_IDLE;
                     crc_reg  <= `MPOC_CRC_INIT;
                  end
               end
            default:
               st_reg <= MPOC_IDLE;
         endcase
      end
   end

   // ready source, on-empty only under generic protocol
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         empty_d_reg <= 1'b1;
         o_tx_rdy    <= 1'b0;
      end
      else
      begin
         empty_d_reg <= ~fifo_valid;
         if (opt_reg[`MPOC_RDY_EMPTY_BIT] && generic)
            o_tx_rdy <= ~fifo_valid & ~empty_d_reg;
         else
            o_tx_rdy <= done_reg;
      end
   end

   // ------------------------------------------------------------
   // time stamp, receive routing and management clock
   // ------------------------------------------------------------
   // capture from the selected detection source
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_ts_capture     <= 1'b0;
         o_rx_lowpri_push <= 1'b0;
         o_admit_gap_err  <= 1'b0;
      end
      else
      begin
         o_ts_capture <= opt_reg[`MPOC_SFD_SRC_BIT] ? mac_evt : phy_evt;
         // unmatched frames, crc kept, to low-priority fifo
         // frame passed whole including its crc32
         o_rx_lowpri_push <= i_rx_unmatched & opt_reg[`MPOC_FWD_UNK_BIT];
         o_admit_gap_err <= opt_reg[`MPOC_GAP_ADM_BIT];
      end
   end

   // rate select, reserved codes run slow
   assign mdc_half = (opt_reg[1:0] == 2'b01) ? 5'(`MPOC_MDC_HALF_FAST)
                                            : 5'(`MPOC_MDC_HALF_SLOW);
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         mdc_div_reg <= '0;
         o_mdc       <= 1'b0;
      end
      else if (mdc_div_reg >= mdc_half - 5'd1)
      begin
         mdc_div_reg <= '0;
         o_mdc       <= ~o_mdc;
      end
      else
         mdc_div_reg <= mdc_div_reg + 5'd1;
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);

   rdy_frame_a : assert property (
      done_reg && !(opt_reg[`MPOC_RDY_EMPTY_BIT] && generic) |=> o_tx_rdy)
      else $error("tx ready missed after frame");
   rdy_proto_a : assert property (
      !generic && !$past(generic) && !$past(done_reg) |-> !o_tx_rdy)
      else $error("tx ready without frame under other protocol");
   ts_phy_a : assert property (
      phy_evt && !opt_reg[`MPOC_SFD_SRC_BIT] |=> o_ts_capture)
      else $error("phy detection not captured");
   ts_mac_a : assert property (
      mac_evt && !phy_evt && opt_reg[`MPOC_SFD_SRC_BIT] |=> o_ts_capture)
      else $error("mac detection not captured");
   cnt_wrap_a : assert property (
      !opt_reg[`MPOC_CLR_RD_BIT] && &cnt_reg[2] && i_cnt_event[2]
      |=> cnt_reg[2] == '0)
      else $error("counter did not wrap");
   cnt_clear_a : assert property (
      i_reg_rd && opt_reg[`MPOC_CLR_RD_BIT] && generic
      && i_reg_addr == `MPOC_CNT_BASE && !i_cnt_event[1]
      |=> cnt_reg[1] == '0)
      else $error("next counter not cleared");
   fcs_flag_a : assert property (
      bad_reg |=> fcs_flag_reg)
      else $error("fcs error not flagged");
   opt_rsv_a : assert property (
      i_reg_rd && i_reg_addr == `MPOC_OPT_ADDR
      |=> o_reg_rdata[31:`MPOC_OPT_RSV_LSB] == `MPOC_OPT_RSV_VAL)
      else $error("reserved field changed");
   low_pri_a : assert property (
      i_rx_unmatched && opt_reg[`MPOC_FWD_UNK_BIT] |=> o_rx_lowpri_push)
      else $error("unmatched frame not forwarded");
   mdc_rate_a : assert property (
      opt_reg[1:0] != 2'b01 && $past(opt_reg[1:0]) != 2'b01
      && $changed(o_mdc) |-> $past(mdc_div_reg) == 5'(`MPOC_MDC_HALF_SLOW - 1))
      else $error("mdc not at slow rate");

   frame_done_c : cover property (done_reg);
   fcs_bad_c    : cover property (bad_reg);
   fifo_full_c  : cover property (!o_tx_ready);
   clr_read_c   : cover property (i_reg_rd && opt_reg[`MPOC_CLR_RD_BIT]);
endmodule
`default_nettype wire

// *** testbench/mac_phy_option_config_bench.sv ***
`include "mpoc_cfg.svh"
`default_nettype none

// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module mac_phy_option_config_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import mpoc_pkg::*;

   logic          i_mclk = 0, i_rst = 1, i_reg_wr = 0, i_reg_rd = 0;
   logic [7:0]    i_reg_addr = 0;
   logic [31:0]   i_reg_wdata = 0, o_reg_rdata, rv;
   logic          i_generic_spi = 1, i_sfd_phy = 0, i_sfd_mac = 0;
   logic [3:0]    i_cnt_event = 0;
   logic          i_rx_unmatched = 0, go = 0, bad = 0, app = 0, link_on = 0;
   logic          link_clk, tx_valid, tx_ready, o_reg_rvalid, o_link_en;
   logic          o_tx_rdy, o_ts_capture, o_mdc, o_rx_lowpri_push, gap;
   logic [7:0]    o_link_data, first_b;
   mpoc_tx_word_t tx_word;
   int            fails = 0, n_tests = 0, cyc = 0, k;
   int            n_bytes = 0, n_rdy = 0, n_cap = 0, n_push = 0;
   int            last_en = 0, rdy_t = 0, n_full = 0;

   always #10 i_mclk = ~i_mclk;

   mpoc_top dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .o_reg_rvalid(o_reg_rvalid), .i_generic_spi(i_generic_spi),
      .i_link_clk(link_clk), .i_sfd_phy(i_sfd_phy), .i_sfd_mac(i_sfd_mac),
      .i_tx_word(tx_word), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
      .o_link_data(o_link_data), .o_link_en(o_link_en),
      .o_tx_rdy(o_tx_rdy), .o_ts_capture(o_ts_capture), .o_mdc(o_mdc),
      .i_cnt_event(i_cnt_event), .i_rx_unmatched(i_rx_unmatched),
      .o_rx_lowpri_push(o_rx_lowpri_push), .o_admit_gap_err(gap));

   mpoc_host_model host (.i_mclk(i_mclk), .i_rst(i_rst), .i_go(go),
      .i_bad(bad), .i_app(app), .i_link_on(link_on), .o_tx_word(tx_word),
      .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_link_clk(link_clk));

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // register strobes: one-cycle pulse, read data one cycle later
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_reg_wr    <= 1'b1;
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      @(posedge i_mclk);
      i_reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_mclk);
      i_reg_rd   <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_mclk);
      i_reg_rd   <= 1'b0;
      #1 d = o_reg_rdata;
      check("read valid", o_reg_rvalid, 1);
   endtask

   task automatic ev(input int idx, input int n);
      repeat (n)
      begin
         @(posedge i_mclk);
         i_cnt_event <= 4'(1 << idx);
         @(posedge i_mclk);
         i_cnt_event <= 4'h0;
      end
   endtask

   // one frame through the fifo; link clock runs only meanwhile
   task automatic frame(input logic b, input logic a);
      int w;
      @(posedge i_mclk);
      n_bytes = 0;
      rdy_t   = 0;
      bad     <= b;
      app     <= a;
      link_on <= 1'b1;
      go      <= 1'b1;
      @(posedge i_mclk);
      go <= 1'b0;
      w = 0;
      while (n_bytes < 8 && w < 2000)
      begin
         @(posedge i_mclk);
         w++;
      end
      repeat (20) @(posedge i_mclk);
      link_on <= 1'b0;
   endtask

   // skip one toggle, then count cycles to the next
   task automatic mdc_half(output int n);
      logic m;
      for (int j = 0; j < 2; j++)
      begin
         n = 0;
         m = o_mdc;
         while (o_mdc === m && n < 50)
         begin
            @(posedge i_mclk);
            #1 n++;
         end
      end
   endtask

   task automatic ts(input logic mac);
      @(posedge i_mclk);
      n_cap = 0;
      if (mac)
         i_sfd_mac <= 1'b1;
      else
         i_sfd_phy <= 1'b1;
      repeat (8) @(posedge i_mclk);
      i_sfd_mac <= 1'b0;
      i_sfd_phy <= 1'b0;
      repeat (4) @(posedge i_mclk);
   endtask

   // output monitor; the ceiling guards against a hang
   always @(posedge i_mclk)
   begin
      cyc++;
      if (o_link_en === 1'b1)
      begin
         if (n_bytes == 0)
            first_b = o_link_data;
         n_bytes++;
         last_en = cyc;
      end
      if (o_tx_rdy === 1'b1)
         rdy_t = cyc;
      if (o_ts_capture === 1'b1)
         n_cap++;
      if (o_rx_lowpri_push === 1'b1)
         n_push++;
      if (tx_ready === 1'b0)
         n_full++;
      if (cyc == 90000)
      begin
         fails++;
         $display("unexpected timeout at cycle %0d", cyc);
         results();
      end
   end

   initial
   begin
      repeat (5) @(posedge i_mclk);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_mclk);
      rd(8'h06, rv);
      check("option reset", rv, `MPOC_OPT_RESET);
      wr(8'h06, 32'hFFFF_FFFF);
      rd(8'h06, rv);
      check("option writable bits", rv, 32'h0000_09FF);
      check("gap admit on", gap, 1);
      rd(8'h20, rv);
      check("unmapped read", rv, 0);
      wr(8'h06, 32'h0);
      repeat (2) @(posedge i_mclk);
      check("gap admit off", gap, 0);
      $display("test registers done");
      // counters: keep, then clear with the next one too
      ev(0, 3);
      rd(8'h10, rv);
      rd(8'h10, rv);
      check("counter kept", rv, 3);
      wr(8'h06, 32'h0000_0040);
      ev(1, 2);
      ev(0, 1);
      rd(8'h10, rv);
      check("counter before clear", rv, 4);
      rd(8'h11, rv);
      check("next counter cleared", rv, 0);
      rd(8'h10, rv);
      check("counter cleared", rv, 0);
      rd(8'h06, rv);
      check("option kept on read", rv, 32'h0000_0840);
      @(posedge i_mclk);
      i_cnt_event <= 4'hC;
      repeat (65540) @(posedge i_mclk);
      i_cnt_event <= 4'h0;
      rd(8'h13, rv);
      check("counter saturated", rv, 32'h0000_FFFF);
      wr(8'h06, 32'h0);
      ev(2, 1);
      rd(8'h12, rv);
      check("counter wrapped", rv, 0);
      $display("test counters done");
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h06, 32'(c));
         repeat (30) @(posedge i_mclk);
         mdc_half(k);
         check("mdc half period", k, (c == 1) ? 6 : 10);
      end
      $display("test mdc done");
      for (int s = 0; s < 2; s++)
      begin
         wr(8'h06, 32'(s << 7));
         for (int p = 0; p < 2; p++)
         begin
            ts(p[0]);
            check("time stamp capture", n_cap, s == p);
         end
      end
      for (int f = 0; f < 2; f++)
      begin
         wr(8'h06, 32'(f << 2));
         @(posedge i_mclk);
         i_rx_unmatched <= 1'b1;
         @(posedge i_mclk);
         i_rx_unmatched <= 1'b0;
         repeat (3) @(posedge i_mclk);
         check("low priority pushes", n_push, f);
      end
      $display("test events done");
      wr(8'h06, 32'h0);
      frame(1'b0, 1'b0);
      check("bytes host fcs", n_bytes, 8);
      check("first byte", first_b, 8'h11);
      check("fifo filled", n_full > 0, 1);
      check("ready after frame", rdy_t > last_en, 1);
      rd(8'h08, rv);
      check("fcs flag good", rv[11], 0);
      frame(1'b1, 1'b0);
      check("bytes bad fcs", n_bytes, 8);
      rd(8'h08, rv);
      check("fcs flag bad", rv[11], 1);
      wr(8'h08, 32'h0000_0800);
      rd(8'h08, rv);
      check("fcs flag cleared", rv[11], 0);
      wr(8'h06, 32'h0000_0120);
      frame(1'b0, 1'b1);
      check("bytes appended fcs", n_bytes, 8);
      check("ready on empty", rdy_t > 0 && rdy_t < last_en, 1);
      @(posedge i_mclk);
      i_generic_spi <= 1'b0;
      repeat (4) @(posedge i_mclk);
      frame(1'b0, 1'b1);
      check("empty mode ignored", rdy_t > last_en, 1);
      $display("test transmit done");
      results();
   end
endmodule
`default_nettype wire

// *** testbench/mpoc_host_model.sv ***
`include "mpoc_cfg.svh"
`default_nettype none

// ------------------------------------------------------------
// host frame source and link clock
// ------------------------------------------------------------
module mpoc_host_model (
   // clock and reset
   input  wire logic                   i_mclk,
   input  wire logic                   i_rst,
   // control from the bench
   input  wire logic                   i_go,
   input  wire logic                   i_bad,
   input  wire logic                   i_app,
   input  wire logic                   i_link_on,
   // transmit stream
   output var  mpoc_pkg::mpoc_tx_word_t o_tx_word,
   output var  logic                   o_tx_valid = 1'b0,
   input  wire logic                   i_tx_ready,
   // link byte clock
   output var  logic                   o_link_clk = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   import mpoc_pkg::*;

   logic [31:0] pay_word = 32'h4433_2211;
   logic [2:0]  idx_reg  = 3'h0;
   logic [63:0] frame;
   logic [7:0]  cur;

   function automatic logic [31:0] fcs_of(input logic [31:0] pay);
      logic [31:0] c;
      c = `MPOC_CRC_INIT;
      for (int i = 0; i < 32; i++)
      begin
         c = (c[0] ^ pay[i]) ? (c >> 1) ^ `MPOC_CRC_POLY : c >> 1;
      end
      return ~c;
   endfunction

   // a bad frame has one fcs bit flipped, only when asked for
   assign frame = {fcs_of(pay_word) ^ {31'h0, i_bad}, pay_word};
   assign cur   = frame[8*idx_reg +: 8];

   // request held until ready is seen at an edge
   always @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_tx_valid <= 1'b0;
         idx_reg    <= 3'h0;
      end
      else if (i_go)
      begin
         o_tx_valid <= 1'b1;
         idx_reg    <= 3'h0;
      end
      else if (o_tx_valid && i_tx_ready)
      begin
         o_tx_valid <= !o_tx_word.last;
         idx_reg    <= idx_reg + 3'h1;
      end
   end

   // released bus shows the inverse so no stale byte looks valid
   assign o_tx_word.data = o_tx_valid ? cur : ~cur;
   assign o_tx_word.last = o_tx_valid && (idx_reg == (i_app ? 3'h3 : 3'h7));

   // link clock runs only inside frames and idles low
   always
   begin
      #80 o_link_clk = i_link_on ? ~o_link_clk : 1'b0;
   end
endmodule
`default_nettype wire
